/* rtl/spi_clock_format_multimaster.sv */
// Serial port core: clock phase/polarity formats, master and slave roles,
// open-drain pins and mode-fault detection on the select input.
// Assumes pins reach it unsynchronised and that the configuration is only
// changed while no character is in flight.
//
// Notes on behaviour
// - Four clock formats picked by a polarity bit and a phase bit.
// - Polarity only inverts the clock; the transfer format stays the same.
// - Phase picks which edge launches data and which edge samples it.
// - Phase 0, polarity 0: launch falling, sample rising, idle low.
// - Phase 0, polarity 1: launch rising, sample falling, idle high.
// - Phase 1, polarity 0: launch rising, sample falling, idle low.
// - Phase 1, polarity 1: launch falling, sample rising, idle high.
// - Both ends of a link must use identical phase and polarity.
// - Master shows each MOSI bit half a clock before the sampling edge.
// - Shared clock and data lines are all driven open-drain.
// - One master at a time; it selects one slave by pulling select low.
// - Master drives clock and MOSI to all; only selected slave drives MISO.
// - Master with select as input flags collision when select goes low.
// - Slave role when enabled, master mode off and select is an input.
// - A character takes as many clocks as the length field says, eight when the field is zero.
`default_nettype none

module spi_clock_format_multimaster (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Configuration and rate
   input wire spi_fmt_pkg::cfg_t cfg,
   input wire logic [15:0] half_period_div,
   // Transmit side
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Receive side
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Status
   output logic busy,
   output logic collision_flag,
   input wire logic collision_clear,
   // Serial clock pin
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   // Master-out line
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   // Master-in line
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n,
   // Select pin, active low
   input wire logic ss_n_in,
   output logic ss_n_out,
   output logic ss_n_oe_n
);

   // Number of bits in one character
   function automatic logic [3:0] char_bits(input logic [2:0] len);
      char_bits = (len == spi_fmt_pkg::LEN_FULL_CODE) ? spi_fmt_pkg::FULL_CHAR_BITS : {1'b0, len};
   endfunction

   // Left-align a short character so that its top bit goes out first
   function automatic logic [7:0] align_tx(input logic [7:0] d, input logic [2:0] len);
      align_tx = d << (spi_fmt_pkg::FULL_CHAR_BITS - char_bits(len));
   endfunction

   // Keep only the received low bits of a short character
   function automatic logic [7:0] keep_rx(input logic [7:0] d, input logic [2:0] len);
      keep_rx = d & ~(8'hFF << char_bits(len));
   endfunction

   // Active-low enable for a pin; open-drain only ever pulls low
   function automatic logic pin_oe_n(input logic drive, input logic bit_val, input logic od);
      pin_oe_n = ~(drive & (~od | ~bit_val));
   endfunction

   // Value placed on a pin; open-drain places only the low level
   function automatic logic pin_val(input logic bit_val, input logic od);
      pin_val = bit_val & ~od;
   endfunction

   logic sck_s1_ff, sck_s2_ff, sck_prev_ff;
   logic mosi_s1_ff, mosi_s2_ff;
   logic miso_s1_ff, miso_s2_ff;
   logic ss_s1_ff, ss_s2_ff, ss_prev_ff;

   spi_fmt_pkg::mst_state_t state_ff;
   logic [15:0] div_cnt_ff;
   logic tick;
   logic [4:0] edge_cnt_ff;
   logic sck_lvl_ff;

   logic [7:0] shreg_ff;
   logic out_bit_ff;
   logic [3:0] bit_cnt_ff;
   logic hold_full_ff;
   logic [7:0] hold_data_ff;
   logic [7:0] rx_data_ff;
   logic rx_valid_ff;
   logic collision_ff;

   logic master_mode, slave_mode, slave_sel, coll_cond;
   logic m_start, m_run, m_lead;
   logic s_edge, s_lead, s_start;
   logic lead_ev, trail_ev, sample_ev, launch_ev, load_ev, done_ev;
   logic sample_in;
   logic [7:0] shifted, load_data;
   logic [3:0] nbits;

   // Pins come from other devices; two stages before anything reads them
   always_ff @(posedge clk) begin
      if (srst) begin
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_prev_ff <= 1'b0;
         mosi_s1_ff <= 1'b0;
         mosi_s2_ff <= 1'b0;
         miso_s1_ff <= 1'b0;
         miso_s2_ff <= 1'b0;
         ss_s1_ff <= 1'b1;
         ss_s2_ff <= 1'b1;
         ss_prev_ff <= 1'b1;
      end else begin
         sck_s1_ff <= sck_in;
         sck_s2_ff <= sck_s1_ff;
         sck_prev_ff <= sck_s2_ff;
         mosi_s1_ff <= mosi_in;
         mosi_s2_ff <= mosi_s1_ff;
         miso_s1_ff <= miso_in;
         miso_s2_ff <= miso_s1_ff;
         ss_s1_ff <= ss_n_in;
         ss_s2_ff <= ss_s1_ff;
         ss_prev_ff <= ss_s2_ff;
      end
   end

   assign slave_mode = cfg.port_enable_bit & ~cfg.master_mode_enable & ~cfg.select_pin_direction;
   assign master_mode = cfg.port_enable_bit & cfg.master_mode_enable;
   // select held low frames the character
   assign slave_sel = slave_mode & ~ss_s2_ff;
   assign coll_cond = master_mode & ~cfg.select_pin_direction & ~ss_s2_ff;

   assign nbits = char_bits(cfg.character_length_field);
   assign load_data = hold_full_ff ? align_tx(hold_data_ff, cfg.character_length_field) : spi_fmt_pkg::CHAR_RESET;

   // Half-period rate enable for the master clock
   assign tick = (div_cnt_ff >= half_period_div);
   always_ff @(posedge clk) begin
      if (srst || state_ff == spi_fmt_pkg::M_IDLE || tick) begin
         div_cnt_ff <= spi_fmt_pkg::DIV_RESET;
      end else begin
         div_cnt_ff <= div_cnt_ff + 16'h0001;
      end
   end

   assign m_start = master_mode & ~coll_cond & hold_full_ff & (state_ff == spi_fmt_pkg::M_IDLE);
   assign m_run = (state_ff == spi_fmt_pkg::M_SHIFT) & tick;
   // leading edge is the one leaving the idle level
   assign m_lead = (sck_lvl_ff == cfg.clock_polarity_sel);

   // two clock edges per bit of the character
   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= spi_fmt_pkg::M_IDLE;
         edge_cnt_ff <= spi_fmt_pkg::EDGECNT_RESET;
      end else if (coll_cond || !master_mode) begin
         // A mode fault aborts the character at once; the pins stay enabled
         state_ff <= spi_fmt_pkg::M_IDLE;
         edge_cnt_ff <= spi_fmt_pkg::EDGECNT_RESET;
      end else begin
         case (state_ff)
            spi_fmt_pkg::M_IDLE: begin
               edge_cnt_ff <= spi_fmt_pkg::EDGECNT_RESET;
               if (m_start) begin
                  state_ff <= spi_fmt_pkg::M_SHIFT;
               end
            end
            spi_fmt_pkg::M_SHIFT: begin
               if (tick) begin
                  edge_cnt_ff <= edge_cnt_ff + 5'h01;
                  if (edge_cnt_ff + 5'h01 == {nbits, 1'b0}) begin
                     state_ff <= spi_fmt_pkg::M_FINISH;
                  end
               end
            end
            spi_fmt_pkg::M_FINISH: begin
               // One idle half period keeps characters apart
               if (tick) begin
                  state_ff <= spi_fmt_pkg::M_IDLE;
               end
            end
            default: begin
               state_ff <= spi_fmt_pkg::M_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sck_lvl_ff <= 1'b0;
      end else if (state_ff != spi_fmt_pkg::M_SHIFT) begin
         sck_lvl_ff <= cfg.clock_polarity_sel;
      end else if (tick) begin
         sck_lvl_ff <= ~sck_lvl_ff;
      end
   end

   // Slave sees edges of the synchronised clock only while selected
   assign s_edge = slave_sel & (sck_s2_ff != sck_prev_ff);
   assign s_lead = (sck_s2_ff != cfg.clock_polarity_sel);
   assign s_start = slave_mode & ~ss_s2_ff & ss_prev_ff;

   assign lead_ev = master_mode ? (m_run & m_lead) : (s_edge & s_lead);
   assign trail_ev = master_mode ? (m_run & ~m_lead) : (s_edge & ~s_lead);
   // phase swaps launch and sample edges
   assign sample_ev = cfg.clock_phase_sel ? trail_ev : lead_ev;
   assign launch_ev = cfg.clock_phase_sel ? lead_ev : trail_ev;
   assign sample_in = master_mode ? miso_s2_ff : mosi_s2_ff;
   assign shifted = {shreg_ff[6:0], sample_in};
   assign done_ev = sample_ev & (bit_cnt_ff + 4'h1 == nbits);
   assign load_ev = m_start | s_start | (slave_sel & done_ev);

   // bit launched half period ahead of sampling
   always_ff @(posedge clk) begin
      if (srst) begin
         shreg_ff <= spi_fmt_pkg::CHAR_RESET;
         out_bit_ff <= 1'b0;
      end else if (load_ev) begin
         // Phase 0 needs the first bit on the line before the first edge
         shreg_ff <= load_data;
         out_bit_ff <= load_data[7];
      end else begin
         if (sample_ev) begin
            shreg_ff <= shifted;
         end
         if (launch_ev) begin
            out_bit_ff <= shreg_ff[7];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || load_ev || !(slave_sel || state_ff == spi_fmt_pkg::M_SHIFT)) begin
         bit_cnt_ff <= spi_fmt_pkg::BITCNT_RESET;
      end else if (sample_ev) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // Single-entry transmit holding register
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_full_ff <= 1'b0;
         hold_data_ff <= spi_fmt_pkg::CHAR_RESET;
      end else if (tx_valid && !hold_full_ff) begin
         hold_full_ff <= 1'b1;
         hold_data_ff <= tx_data;
      end else if (load_ev) begin
         hold_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_data_ff <= spi_fmt_pkg::CHAR_RESET;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= done_ev;
         if (done_ev) begin
            rx_data_ff <= keep_rx(shifted, cfg.character_length_field);
         end
      end
   end

   // sticky mode fault, set wins over clear
   always_ff @(posedge clk) begin
      if (srst) begin
         collision_ff <= 1'b0;
      end else if (coll_cond) begin
         collision_ff <= 1'b1;
      end else if (collision_clear) begin
         collision_ff <= 1'b0;
      end
   end

   assign tx_ready = ~hold_full_ff;
   assign rx_data = rx_data_ff;
   assign rx_valid = rx_valid_ff;
   assign busy = (state_ff != spi_fmt_pkg::M_IDLE) | slave_sel;
   assign collision_flag = collision_ff;

   // master drives clock and MOSI, selected slave drives MISO
   assign sck_out = pin_val(sck_lvl_ff, cfg.open_drain_en);
   assign sck_oe_n = pin_oe_n(master_mode, sck_lvl_ff, cfg.open_drain_en);
   assign mosi_out = pin_val(out_bit_ff, cfg.open_drain_en);
   assign mosi_oe_n = pin_oe_n(master_mode, out_bit_ff, cfg.open_drain_en);
   assign miso_out = pin_val(out_bit_ff, cfg.open_drain_en);
   assign miso_oe_n = pin_oe_n(slave_sel, out_bit_ff, cfg.open_drain_en);
   // master selects its slave by pulling select low
   assign ss_n_out = (state_ff == spi_fmt_pkg::M_IDLE);
   assign ss_n_oe_n = ~(master_mode & cfg.select_pin_direction);

endmodule

`default_nettype wire

/* rtl/spi_fmt_pkg.sv */
// Constants, state codes and the configuration carrier of the serial port.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
`default_nettype none

package spi_fmt_pkg;

   // Character and counter widths
   localparam int CHAR_W = 8;
   localparam int LEN_W = 3;
   localparam int DIV_W = 16;
   localparam int BITCNT_W = 4;
   localparam int EDGECNT_W = 5;

   // Length field value that stands for a full character
   localparam logic [LEN_W-1:0] LEN_FULL_CODE = 3'h0;
   localparam logic [BITCNT_W-1:0] FULL_CHAR_BITS = 4'h8;

   // Reset values
   localparam logic [CHAR_W-1:0] CHAR_RESET = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam logic [BITCNT_W-1:0] BITCNT_RESET = 4'h0;
   localparam logic [EDGECNT_W-1:0] EDGECNT_RESET = 5'h00;

   // Master sequencer states, Gray coded along idle -> shift -> finish
   typedef enum logic [1:0] {
      M_IDLE = 2'h0,
      M_SHIFT = 2'h1,
      M_FINISH = 2'h3
   } mst_state_t;

   // Port configuration, held steady by software while a character runs
   typedef struct packed {
      logic port_enable_bit;
      logic master_mode_enable;
      logic select_pin_direction;
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic open_drain_en;
      logic [LEN_W-1:0] character_length_field;
   } cfg_t;

endpackage

`default_nettype wire

/* testbench/spi_clock_format_multimaster_test.sv */
// Bench: master rows against a far-side slave, then collision and slave role.
// Lines resolve as wired-and with pull-ups; bench drivers release to 1.
`default_nettype none
module spi_clock_format_multimaster_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic cpol; logic cpha; logic [2:0] len; logic [7:0] mtx; logic [7:0] ptx;} row_t;
   row_t rows [5] = '{'{1'h0, 1'h0, 3'h0, 8'hA5, 8'h3C}, '{1'h1, 1'h0, 3'h0, 8'h81, 8'hC3},
      '{1'h0, 1'h1, 3'h0, 8'h7E, 8'h18}, '{1'h1, 1'h1, 3'h0, 8'h4B, 8'hE1}, '{1'h0, 1'h0, 3'h5, 8'h16, 8'h9F}};
   logic clk = 1'b0;
   logic srst = 1'b1;
   spi_fmt_pkg::cfg_t cfg = '0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic coll_clr = 1'b0;
   logic sck_ext = 1'b1;
   logic mosi_ext = 1'b1;
   logic ss_ext = 1'b1;
   logic p_en = 1'b0;
   logic [7:0] p_tx = 8'h00;
   logic tx_ready, rx_valid, busy, coll, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   logic ss_n_out, ss_n_oe_n, miso_drv_n, sck_w, mosi_w, miso_w, ss_w;
   logic [7:0] rx_data, p_rx, got, mask;
   logic [4:0] p_cnt;
   int error_cnt = 0;
   int cmp_count = 0;
   int i, n, b;
   assign sck_w = (sck_oe_n | sck_out) & sck_ext;
   assign mosi_w = (mosi_oe_n | mosi_out) & mosi_ext;
   assign miso_w = (miso_oe_n | miso_out) & miso_drv_n;
   assign ss_w = (ss_n_oe_n | ss_n_out) & ss_ext;
   always #10 clk = ~clk;
   spi_clock_format_multimaster dut (.clk(clk), .srst(srst), .cfg(cfg), .half_period_div(16'h0003),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .busy(busy), .collision_flag(coll), .collision_clear(coll_clr), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n));
   spi_far_slave peer (.en(p_en), .cpol(cfg.clock_polarity_sel), .cpha(cfg.clock_phase_sel), .tx_byte(p_tx),
      .sck_w(sck_w), .mosi_w(mosi_w), .miso_drv_n(miso_drv_n), .rx_byte(p_rx), .edge_cnt(p_cnt));
   task chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task send(input logic [7:0] d);
      tx_data <= d;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
   endtask
   task wait_rx;
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < 400) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (rx_valid !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: no character received", $time);
         test_done;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk(tx_ready === 1'b1 && rx_valid === 1'b0 && rx_data === 8'h00 && coll === 1'b0 && busy === 1'b0, "reset");
      $display("Test reset done");
      for (i = 0; i < 5; i++) begin
         @(posedge clk);
         cfg <= '{1'b1, 1'b1, 1'b0, rows[i].cpol, rows[i].cpha, 1'b1, rows[i].len};
         p_tx <= rows[i].ptx;
         repeat (4) @(posedge clk);
         p_en <= 1'b1;
         send(rows[i].mtx);
         wait_rx;
         repeat (8) @(posedge clk);
         #1;
         n = (rows[i].len == 3'h0) ? 8 : rows[i].len;
         mask = 8'hFF >> (8 - n);
         chk(rx_data === (rows[i].ptx >> (8 - n)), "received character");
         chk((p_rx & mask) === (rows[i].mtx & mask), "MOSI character");
         chk(p_cnt === n, "sampling edge count");
         chk(sck_w === rows[i].cpol, "idle clock level");
         p_en <= 1'b0;
         $display("Test row %0d done", i);
      end
      // Let the peer see its enable fall before it rises again
      @(posedge clk);
      cfg <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0};
      p_en <= 1'b1;
      send(8'hC5);
      repeat (10) @(posedge clk);
      ss_ext <= 1'b0;
      repeat (6) @(posedge clk);
      chk(coll === 1'b1, "collision flag set");
      ss_ext <= 1'b1;
      p_en <= 1'b0;
      repeat (10) @(posedge clk);
      chk(coll === 1'b1 && busy === 1'b0, "flag sticky, transfer aborted");
      coll_clr <= 1'b1;
      @(posedge clk);
      coll_clr <= 1'b0;
      @(posedge clk);
      #1;
      chk(coll === 1'b0, "collision flag cleared");
      $display("Test collision done");
      // Master drives its own select push-pull; nobody drives MISO
      cfg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0};
      send(8'h5A);
      repeat (3) @(posedge clk);
      #1;
      chk(ss_n_out === 1'b0 && ss_n_oe_n === 1'b0 && sck_oe_n === 1'b0 && busy === 1'b1, "select low");
      wait_rx;
      chk(rx_data === 8'hFF, "released MISO reads high");
      repeat (8) @(posedge clk);
      #1;
      chk(ss_n_out === 1'b1 && sck_w === 1'b1 && sck_oe_n === 1'b0, "select high, clock idle");
      $display("Test select output done");
      cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0};
      sck_ext <= 1'b0;
      send(8'h96);
      // select low before and through the character
      ss_ext <= 1'b0;
      repeat (4) @(posedge clk);
      chk(busy === 1'b1, "slave selected");
      for (b = 7; b >= 0; b--) begin
         mosi_ext <= b[0] ? 1'b1 : 1'b0;
         repeat (4) @(posedge clk);
         sck_ext <= 1'b1;
         got[b] = miso_w;
         repeat (4) @(posedge clk);
         sck_ext <= 1'b0;
      end
      ss_ext <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk(rx_data === 8'hAA, "slave received");
      chk(got === 8'h96, "slave MISO character");
      chk(miso_oe_n === 1'b1, "MISO released");
      $display("Test slave done");
      test_done;
   end
endmodule
`default_nettype wire

/* testbench/spi_far_slave.sv */
// Behavioural slave on the far side of the shared serial lines.
// Assumes the bench resolves every line with a pull-up.
`default_nettype none
module spi_far_slave (
   // Mode and data
   input wire logic en,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   // Lines
   input wire logic sck_w,
   input wire logic mosi_w,
   output logic miso_drv_n,
   // Observation
   output logic [7:0] rx_byte,
   output logic [4:0] edge_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] idx = 3'h7;
   logic bit_q = 1'b1;
   assign miso_drv_n = ~en | bit_q;
   always @(posedge en) begin
      idx = 3'h7;
      bit_q = cpha | tx_byte[7];
      rx_byte = 8'h00;
      edge_cnt = 5'h00;
   end
   always @(sck_w) begin
      if (en) begin
         if ((sck_w != cpol) == cpha) begin
            if (cpha) begin
               bit_q = tx_byte[idx];
               idx = idx - 3'h1;
            end else begin
               idx = idx - 3'h1;
               bit_q = tx_byte[idx];
            end
         end else begin
            rx_byte = {rx_byte[6:0], mosi_w};
            edge_cnt = edge_cnt + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/spi_fmt_props.sv */
// Pin and status checker for the serial port core.
// Sees only the core's ports; open-drain lines are read with a pull-up.
`default_nettype none
module spi_fmt_props (
   // Clock, reset, configuration
   input wire logic clk,
   input wire logic srst,
   input wire spi_fmt_pkg::cfg_t cfg,
   // Status
   input wire logic busy,
   input wire logic collision_flag,
   input wire logic collision_clear,
   // Pins
   input wire logic sck_out,
   input wire logic sck_oe_n,
   input wire logic mosi_out,
   input wire logic mosi_oe_n,
   input wire logic miso_out,
   input wire logic miso_oe_n,
   input wire logic ss_n_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   logic mst;
   logic slv;
   logic sck_lvl;
   logic mosi_lvl;
   assign mst = cfg.port_enable_bit & cfg.master_mode_enable;
   assign slv = cfg.port_enable_bit & ~cfg.master_mode_enable & ~cfg.select_pin_direction;
   assign sck_lvl = sck_oe_n | sck_out;
   assign mosi_lvl = mosi_oe_n | mosi_out;
   // A polarity held for three idle cycles gives the clock level register time to follow it
   idle_level_a: assert property ((mst && !busy && $stable(cfg.clock_polarity_sel)) [*3]
      |-> sck_lvl == cfg.clock_polarity_sel)
      else $error("clock not at idle level");
   open_drain_a: assert property (cfg.open_drain_en |-> !(sck_out | mosi_out | miso_out))
      else $error("open-drain pin driven high");
   sample_stable_a: assert property (mst && busy && ss_n_in && $changed(sck_lvl)
      && sck_lvl != (cfg.clock_polarity_sel ^ cfg.clock_phase_sel) |-> $stable(mosi_lvl) ##1 $stable(mosi_lvl))
      else $error("MOSI moved at sampling edge");
   collision_set_a: assert property ((mst && !cfg.select_pin_direction && !ss_n_in) [*4]
      |-> ##[0:2] collision_flag)
      else $error("collision not flagged");
   flag_sticky_a: assert property (collision_flag && !collision_clear |=> collision_flag)
      else $error("collision flag lost");
   master_miso_a: assert property (mst |-> miso_oe_n)
      else $error("master drives MISO");
   slave_release_a: assert property ((slv && ss_n_in) [*4] |-> miso_oe_n)
      else $error("unselected slave drives MISO");
   slave_busy_a: assert property ((slv && !ss_n_in) [*4] |-> busy)
      else $error("selected slave not busy");
   cover property (mst && busy);
   cover property (slv && busy);
   cover property ($rose(collision_flag));
endmodule
bind spi_clock_format_multimaster spi_fmt_props u_props (.clk(clk), .srst(srst), .cfg(cfg), .busy(busy),
   .collision_flag(collision_flag), .collision_clear(collision_clear), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
   .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in));
`default_nettype wire
